/* File: include/iocs_defines.vh */
`ifndef IOCS_DEFINES_VH
`define IOCS_DEFINES_VH
`define IOCS_A_CTRL     8'h00
`define IOCS_A_STAT     8'h04
`define IOCS_A_LEVEL    8'h08
`define IOCS_A_CLAMP    8'h0C
`define IOCS_A_THRSRC   8'h10
`define IOCS_A_MODELO   8'h14
`define IOCS_A_MODEHI   8'h18
`define IOCS_A_DEFLO    8'h1C
`define IOCS_A_DEFHI    8'h20
`define IOCS_A_INDEX    8'h24
`define IOCS_A_THRPAR   8'h28
`define IOCS_A_BIND     8'h2C
`define IOCS_A_FRAC     8'h30
`define IOCS_A_ISTAT    8'h34
`define IOCS_A_ICLR     8'h38
`define IOCS_A_IEN      8'h3C
`define IOCS_C_RUN      0
`define IOCS_C_INIT     1
`define IOCS_C_TRIPCLR  2
`define IOCS_C_DATADEP  3
`define IOCS_B_UNUSED   7
`define IOCS_B_TMOCHK   6
`define IOCS_RST_BIND   8'h80
`define IOCS_RST_FRAC   16'h0000
`define IOCS_IO_PLAIN   2'h0
`define IOCS_IO_PU      2'h1
`define IOCS_IO_PD      2'h2
`define IOCS_IO_OUT     2'h3
`define IOCS_SW_HIZ     3'h0
`define IOCS_SW_PU      3'h1
`define IOCS_SW_PD      3'h2
`define IOCS_SW_BATT    3'h3
`define IOCS_SW_GND     3'h4
`define IOCS_EXP_OK     2'h0
`define IOCS_EXP_TMO    2'h1
`define IOCS_EXP_UNUSED 2'h2
`define IOCS_I_TRIP     0
`define IOCS_I_TMO      1
`define IOCS_I_XFER     2
`endif

/* File: verilog/iocs_top.v */
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "iocs_defines.vh"
module iocs_top #(
  parameter NCH  = 32,
  parameter NIO  = 16,
  parameter NMV  = 64,
  parameter TW   = 8,
  parameter VW   = 16,
  parameter VMAX = 720
)(
  input  wire              clk,
  input  wire              rst_b,
  input  wire [7:0]        addr,
  input  wire [31:0]       wdata,
  input  wire              wr,
  input  wire              rd,
  output reg  [31:0]       rdata,
  output wire              irq,
  input  wire              step_tick,
  input  wire              board_enable,
  input  wire [NCH-1:0]    cmp_level_pin,
  input  wire [NIO-1:0]    clamp_pin,
  input  wire              overcurrent_pin,
  input  wire [NCH-1:0]    channel_off,
  input  wire [NCH*TW-1:0] compare_threshold,
  input  wire [NIO*3-1:0]  switch_config,
  input  wire [NMV-1:0]    timeout_hit,
  input  wire [VW-1:0]     xfer_value,
  output reg  [NCH-1:0]    channel_level_mask,
  output reg  [NIO-1:0]    current_clamp_mask,
  output reg               overload_trip,
  output reg               battery_supply_off,
  output reg  [NCH*TW-1:0] threshold_out,
  output reg  [NCH-1:0]    chan_active,
  output reg  [NCH-1:0]    in_pull_up,
  output reg  [NCH-1:0]    in_pull_down,
  output reg  [NIO-1:0]    sw_pull_up,
  output reg  [NIO-1:0]    sw_pull_down,
  output reg  [NIO-1:0]    sw_direct_batt,
  output reg  [NIO-1:0]    sw_direct_gnd,
  output reg  [NMV-1:0]    measure_run,
  output reg  [NMV*2-1:0]  expiry_status,
  output reg  [VW-1:0]     xfer_data,
  output reg               xfer_strobe
);
  reg  [NCH-1:0]  lvl_s1;
  reg  [NCH-1:0]  lvl_s2;
  reg  [NIO-1:0]  clp_s1;
  reg  [NIO-1:0]  clp_s2;
  reg             oc_s1;
  reg             oc_s2;
  reg  [3:0]      ctrl;
  reg  [NCH-1:0]  thr_src;
  reg  [63:0]     io_mode;
  reg  [47:0]     def_sw;
  reg  [5:0]      index;
  reg  [15:0]     frac;
  reg  [2:0]      istat;
  reg  [2:0]      ien;
  reg             trip;
  reg  [NMV-1:0]  tmo_pend;
  reg  [VW-1:0]   last_xfer;
  reg  [TW-1:0]   thr_par [0:NCH-1];
  reg  [7:0]      bind_tab [0:NMV-1];
  reg  [2:0]      sw_code [0:NIO-1];
  reg  [NMV-1:0]  tmo_now;
  reg  [NMV*2-1:0] next_expiry;
  reg  [NMV-1:0]  next_run;
  wire            w_ctrl;
  wire            init_pls;
  wire            trip_clr;
  wire            step_on;
  wire [31:0]     prod;
  wire [VW-1:0]   delta;
  wire [VW-1:0]   absdiff;
  wire            xfer_go;
  wire [2:0]      ev;
  integer         i, i_r, i_t, i_c, i_d;

  assign w_ctrl   = wr && (addr == `IOCS_A_CTRL);
  assign init_pls = w_ctrl && wdata[`IOCS_C_INIT];
  assign trip_clr = w_ctrl && wdata[`IOCS_C_TRIPCLR];
  // no evaluation while the board is disabled
  assign step_on  = step_tick && board_enable && ctrl[`IOCS_C_RUN];

  // pin inputs cross into clk before any use
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_s1 <= {NCH{1'b0}};
      lvl_s2 <= {NCH{1'b0}};
      clp_s1 <= {NIO{1'b0}};
      clp_s2 <= {NIO{1'b0}};
      oc_s1  <= 1'b0;
      oc_s2  <= 1'b0;
    end else begin
      lvl_s1 <= cmp_level_pin;
      lvl_s2 <= lvl_s1;
      clp_s1 <= clamp_pin;
      clp_s2 <= clp_s1;
      oc_s1  <= overcurrent_pin;
      oc_s2  <= oc_s1;
    end
  end

  // software registers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl    <= 4'h0;
      thr_src <= {NCH{1'b0}};
      io_mode <= 64'h0;
      def_sw  <= 48'h0;
      index   <= 6'h00;
      frac    <= `IOCS_RST_FRAC;
      ien     <= 3'h0;
      for (i_r = 0; i_r < NCH; i_r = i_r + 1)
        thr_par[i_r] <= {TW{1'b0}};
      for (i_r = 0; i_r < NMV; i_r = i_r + 1)
        bind_tab[i_r] <= `IOCS_RST_BIND;
    end else if (wr) begin
      case (addr)
        `IOCS_A_CTRL: begin
          ctrl[`IOCS_C_RUN]     <= wdata[`IOCS_C_RUN];
          ctrl[`IOCS_C_DATADEP] <= wdata[`IOCS_C_DATADEP];
        end
        `IOCS_A_THRSRC: thr_src <= wdata[NCH-1:0];
        `IOCS_A_MODELO: io_mode[31:0] <= wdata;
        `IOCS_A_MODEHI: io_mode[63:32] <= wdata;
        `IOCS_A_DEFLO:  def_sw[23:0] <= wdata[23:0];
        `IOCS_A_DEFHI:  def_sw[47:24] <= wdata[23:0];
        `IOCS_A_INDEX:  index <= wdata[5:0];
        `IOCS_A_THRPAR: thr_par[index[4:0]] <= wdata[TW-1:0];
        `IOCS_A_BIND:   bind_tab[index] <= wdata[7:0];
        `IOCS_A_FRAC:   frac <= wdata[15:0];
        `IOCS_A_IEN:    ien <= wdata[2:0];
        default: ;
      endcase
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 32'h0;
    end else if (rd) begin
      case (addr)
        `IOCS_A_CTRL:   rdata <= {28'h0, ctrl[3], 2'h0, ctrl[0]};
        `IOCS_A_STAT:   rdata <= {29'h0, board_enable, oc_s2, trip};
        `IOCS_A_LEVEL:  rdata <= channel_level_mask;
        `IOCS_A_CLAMP:  rdata <= {16'h0, current_clamp_mask};
        `IOCS_A_THRSRC: rdata <= thr_src;
        `IOCS_A_MODELO: rdata <= io_mode[31:0];
        `IOCS_A_MODEHI: rdata <= io_mode[63:32];
        `IOCS_A_DEFLO:  rdata <= {8'h0, def_sw[23:0]};
        `IOCS_A_DEFHI:  rdata <= {8'h0, def_sw[47:24]};
        `IOCS_A_INDEX:  rdata <= {26'h0, index};
        `IOCS_A_THRPAR: rdata <= {{(32-TW){1'b0}}, thr_par[index[4:0]]};
        `IOCS_A_BIND:   rdata <= {24'h0, bind_tab[index]};
        `IOCS_A_FRAC:   rdata <= {16'h0, frac};
        `IOCS_A_ISTAT:  rdata <= {29'h0, istat};
        `IOCS_A_IEN:    rdata <= {29'h0, ien};
        default:        rdata <= 32'h0;
      endcase
    end
  end

  // trip is sticky; a new overcurrent beats a clear in the same cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      trip <= 1'b0;
    else if (oc_s2)
      trip <= 1'b1;
    else if (trip_clr)
      trip <= 1'b0;
  end

  // snapshot so the model never sees a torn set of masks
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_level_mask <= {NCH{1'b0}};
      current_clamp_mask <= {NIO{1'b0}};
      overload_trip      <= 1'b0;
    end else if (step_tick) begin
      overload_trip <= trip;
      if (board_enable) begin
        channel_level_mask <= lvl_s2 & ~channel_off;
        current_clamp_mask <= clp_s2;
      end
    end
  end

  // threshold source per channel
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      threshold_out <= {(NCH*TW){1'b0}};
      chan_active   <= {NCH{1'b0}};
      in_pull_up    <= {NCH{1'b0}};
      in_pull_down  <= {NCH{1'b0}};
    end else begin
      for (i_t = 0; i_t < NCH; i_t = i_t + 1) begin
        threshold_out[i_t*TW +: TW] <= thr_src[i_t] ? compare_threshold[i_t*TW +: TW]
                                                    : thr_par[i_t];
        chan_active[i_t]  <= board_enable && !channel_off[i_t] && !trip;
        in_pull_up[i_t]   <= io_mode[2*i_t +: 2] == `IOCS_IO_PU;
        in_pull_down[i_t] <= io_mode[2*i_t +: 2] == `IOCS_IO_PD;
      end
    end
  end

  // switch codes: defaults on init, model codes while running
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i_c = 0; i_c < NIO; i_c = i_c + 1)
        sw_code[i_c] <= `IOCS_SW_HIZ;
    end else if (init_pls) begin
      for (i_c = 0; i_c < NIO; i_c = i_c + 1)
        sw_code[i_c] <= def_sw[3*i_c +: 3];
    end else if (step_tick && ctrl[`IOCS_C_RUN]) begin
      for (i_c = 0; i_c < NIO; i_c = i_c + 1)
        sw_code[i_c] <= switch_config[3*i_c +: 3];
    end
  end

  // only channels 0..15 have a switch; an out-of-range code floats
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_pull_up     <= {NIO{1'b0}};
      sw_pull_down   <= {NIO{1'b0}};
      sw_direct_batt <= {NIO{1'b0}};
      sw_direct_gnd  <= {NIO{1'b0}};
      battery_supply_off <= 1'b0;
    end else begin
      battery_supply_off <= trip;
      for (i_d = 0; i_d < NIO; i_d = i_d + 1) begin
        if (trip || io_mode[2*i_d +: 2] != `IOCS_IO_OUT || channel_off[i_d]) begin
          sw_pull_up[i_d]     <= 1'b0;
          sw_pull_down[i_d]   <= 1'b0;
          sw_direct_batt[i_d] <= 1'b0;
          sw_direct_gnd[i_d]  <= 1'b0;
        end else begin
          sw_pull_up[i_d]     <= sw_code[i_d] == `IOCS_SW_PU;
          sw_pull_down[i_d]   <= sw_code[i_d] == `IOCS_SW_PD;
          sw_direct_batt[i_d] <= sw_code[i_d] == `IOCS_SW_BATT;
          sw_direct_gnd[i_d]  <= sw_code[i_d] == `IOCS_SW_GND;
        end
      end
    end
  end

  // expiry per measured value
  always @* begin
    tmo_now     = {NMV{1'b0}};
    next_expiry = expiry_status;
    next_run    = {NMV{1'b0}};
    for (i = 0; i < NMV; i = i + 1) begin
      next_run[i] = !bind_tab[i][`IOCS_B_UNUSED] && board_enable;
      tmo_now[i]  = bind_tab[i][`IOCS_B_TMOCHK] &&
                    (tmo_pend[i] || timeout_hit[i] || channel_off[bind_tab[i][4:0]]);
      if (bind_tab[i][`IOCS_B_UNUSED])
        next_expiry[2*i +: 2] = `IOCS_EXP_UNUSED;
      else if (tmo_now[i])
        next_expiry[2*i +: 2] = `IOCS_EXP_TMO;
      else
        next_expiry[2*i +: 2] = `IOCS_EXP_OK;
    end
  end

  // hits between steps are held while board_enable is high; a hit in the step cycle counts for that step and is not held
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tmo_pend      <= {NMV{1'b0}};
      expiry_status <= {NMV{`IOCS_EXP_UNUSED}};
      measure_run   <= {NMV{1'b0}};
    end else begin
      measure_run <= next_run;
      if (step_on) begin
        tmo_pend      <= {NMV{1'b0}};
        expiry_status <= next_expiry;
      end else if (board_enable) begin
        tmo_pend <= tmo_pend | timeout_hit;
      end
    end
  end

  // data-dependent transfer of the tracked value
  assign prod    = VMAX * frac;
  // rounded up: a change below the set fraction must never send
  assign delta   = prod[31:16] + {{(VW-1){1'b0}}, |prod[15:0]};
  assign absdiff = (xfer_value >= last_xfer) ? xfer_value - last_xfer : last_xfer - xfer_value;
  assign xfer_go = step_on && (!ctrl[`IOCS_C_DATADEP] || absdiff >= delta);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_xfer   <= {VW{1'b0}};
      xfer_data   <= {VW{1'b0}};
      xfer_strobe <= 1'b0;
    end else begin
      xfer_strobe <= xfer_go;
      if (xfer_go) begin
        last_xfer <= xfer_value;
        xfer_data <= xfer_value;
      end
    end
  end

  // interrupt status: set wins over clear
  assign ev[`IOCS_I_TRIP] = oc_s2 && !trip;
  assign ev[`IOCS_I_TMO]  = step_on && |tmo_now;
  assign ev[`IOCS_I_XFER] = xfer_go;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      istat <= 3'h0;
    else if (wr && addr == `IOCS_A_ICLR)
      istat <= (istat & ~wdata[2:0]) | ev;
    else
      istat <= istat | ev;
  end

  assign irq = |(istat & ien);
endmodule

/* File: tb/iocs_chk.sv */
`timescale 1ns/1ns
module iocs_chk #(
  parameter NCH = 32,
  parameter NIO = 16
)(
  input wire           clk,
  input wire           rst_b,
  input wire [7:0]     addr,
  input wire [31:0]    wdata,
  input wire           wr,
  input wire           step_tick,
  input wire           board_enable,
  input wire [NCH-1:0] channel_off,
  input wire [NCH-1:0] chan_active,
  input wire [NCH-1:0] channel_level_mask,
  input wire [NIO-1:0] current_clamp_mask,
  input wire           overload_trip,
  input wire           battery_supply_off,
  input wire [NIO-1:0] sw_pull_up,
  input wire [NIO-1:0] sw_pull_down,
  input wire [NIO-1:0] sw_direct_batt,
  input wire [NIO-1:0] sw_direct_gnd,
  input wire           xfer_strobe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire           clr_wr = wr && addr == 8'h00 && wdata[2];
  wire [NIO-1:0] drv    = sw_pull_up | sw_pull_down | sw_direct_batt | sw_direct_gnd;
  wire [NIO-1:0] clash  = (sw_pull_up & (sw_pull_down | sw_direct_batt | sw_direct_gnd))
                        | (sw_pull_down & (sw_direct_batt | sw_direct_gnd)) | (sw_direct_batt & sw_direct_gnd);
  // clear written, snapshot not yet refreshed by a step
  reg            clr_since;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      clr_since <= 1'b0;
    else if (clr_wr)
      clr_since <= 1'b1;
    else if (step_tick)
      clr_since <= 1'b0;
  end
  sequence s_tripped;
    overload_trip [*2];
  endsequence
  a_trip_latch: assert property (overload_trip && !(step_tick && clr_since) |=> overload_trip)
    else $error("trip dropped without clear");
  a_supply_cut: assert property (overload_trip && !clr_since |=> battery_supply_off)
    else $error("supply not cut after trip");
  a_trip_idle: assert property (overload_trip && !clr_since |=> chan_active == 0)
    else $error("channel active while tripped");
  a_switch_drop: assert property (s_tripped ##0 !clr_since |=> drv == 0)
    else $error("switch driven while tripped");
  a_one_drive: assert property (clash == 0)
    else $error("two switch drives on one channel");
  a_enable_gate: assert property (!board_enable |=> chan_active == 0)
    else $error("channel active while board disabled");
  a_off_gate: assert property ((chan_active & $past(channel_off)) == 0)
    else $error("disabled channel active");
  a_snap_hold: assert property (!step_tick |=> $stable(channel_level_mask) && $stable(current_clamp_mask))
    else $error("snapshot moved without step");
  a_xfer_cause: assert property (xfer_strobe |-> $past(step_tick) && $past(board_enable))
    else $error("transfer without enabled step");
endmodule
bind iocs_top iocs_chk #(.NCH(NCH), .NIO(NIO)) u_chk (
  .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .step_tick(step_tick),
  .board_enable(board_enable), .channel_off(channel_off), .chan_active(chan_active),
  .channel_level_mask(channel_level_mask), .current_clamp_mask(current_clamp_mask),
  .overload_trip(overload_trip), .battery_supply_off(battery_supply_off), .sw_pull_up(sw_pull_up),
  .sw_pull_down(sw_pull_down), .sw_direct_batt(sw_direct_batt), .sw_direct_gnd(sw_direct_gnd),
  .xfer_strobe(xfer_strobe));

/* File: tb/iocs_model.sv */
`timescale 1ns/1ns
module iocs_model (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        go,
  input  wire [15:0] angle,
  input  wire        xfer_strobe,
  input  wire [15:0] xfer_data,
  output reg         step_tick,
  output reg  [15:0] xfer_value,
  output reg  [7:0]  rx_cnt,
  output reg  [15:0] rx_data
);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      step_tick <= 1'b0;
      xfer_value <= 16'h0000;
      rx_cnt <= 8'h00;
      rx_data <= 16'h0000;
    end else begin
      step_tick <= go;
      // angle clipped so a bad request never leaves the legal range
      xfer_value <= (angle > 16'h02D0) ? 16'h02D0 : angle;
      if (xfer_strobe) begin
        rx_cnt <= rx_cnt + 8'h01;
        rx_data <= xfer_data;
      end
    end
  end
endmodule

/* File: tb/io_channel_status_control_tb_top.sv */
`timescale 1ns/1ns
`include "iocs_defines.vh"
module io_channel_status_control_tb_top;
  reg          clk = 1'b0;
  reg          rst_b = 1'b0;
  reg  [7:0]   addr = 8'h00;
  reg  [31:0]  wdata = 32'h0;
  reg          wr = 1'b0;
  reg          rd = 1'b0;
  reg          go = 1'b0;
  reg          board_enable = 1'b0;
  reg  [31:0]  cmp_level_pin = 32'h0;
  reg  [15:0]  clamp_pin = 16'h0;
  reg          overcurrent_pin = 1'b0;
  reg  [31:0]  channel_off = 32'h0;
  reg  [255:0] compare_threshold = {32{8'hC3}};
  reg  [47:0]  switch_config = 48'h0;
  reg  [63:0]  timeout_hit = 64'h0;
  reg  [15:0]  angle = 16'h0;
  reg  [7:0]   n0;
  wire [31:0]  rdata, level, chan_active, in_pu, in_pd;
  wire [15:0]  clamp, sw_pu, sw_pd, sw_batt, sw_gnd, xfer_value, xfer_data, rx_data;
  wire [255:0] thr_out;
  wire [63:0]  measure_run;
  wire [127:0] expiry;
  wire [7:0]   rx_cnt;
  wire         irq, step_tick, xfer_strobe, overload_trip, supply_off;
  integer      miscompares, n_compared, i;
  always #5 clk = ~clk;
  iocs_top uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq), .step_tick(step_tick), .board_enable(board_enable), .cmp_level_pin(cmp_level_pin),
    .clamp_pin(clamp_pin), .overcurrent_pin(overcurrent_pin), .channel_off(channel_off),
    .compare_threshold(compare_threshold), .switch_config(switch_config), .timeout_hit(timeout_hit),
    .xfer_value(xfer_value), .channel_level_mask(level), .current_clamp_mask(clamp),
    .overload_trip(overload_trip), .battery_supply_off(supply_off), .threshold_out(thr_out),
    .chan_active(chan_active), .in_pull_up(in_pu), .in_pull_down(in_pd), .sw_pull_up(sw_pu),
    .sw_pull_down(sw_pd), .sw_direct_batt(sw_batt), .sw_direct_gnd(sw_gnd), .measure_run(measure_run),
    .expiry_status(expiry), .xfer_data(xfer_data), .xfer_strobe(xfer_strobe));
  iocs_model u_model (.clk(clk), .rst_b(rst_b), .go(go), .angle(angle), .xfer_strobe(xfer_strobe),
    .xfer_data(xfer_data), .step_tick(step_tick), .xfer_value(xfer_value), .rx_cnt(rx_cnt),
    .rx_data(rx_data));
  task chk(input [255:0] seen, input [255:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
    end
  endtask
  task rd_reg(input [7:0] a, input [31:0] exp);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
    end
  endtask
  task step;
    begin
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  task give_verdict;
    begin
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // whole run is well under a thousand cycles; this is twenty times that
  initial begin
    #200000;
    miscompares = miscompares + 1;
    give_verdict;
  end
  initial begin
    miscompares = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk(expiry, {64{2'h2}});
    rd_reg(`IOCS_A_BIND, 32'h80);
    rd_reg(8'h40, 32'h0);
    $display("test reset done");
    @(posedge clk);
    board_enable <= 1'b1;
    cmp_level_pin <= 32'hA5C30F18;
    clamp_pin <= 16'h8421;
    channel_off <= 32'h8;
    step;
    chk(level, 32'hA5C30F10);
    chk(clamp, 16'h8421);
    rd_reg(`IOCS_A_LEVEL, 32'hA5C30F10);
    @(posedge clk);
    board_enable <= 1'b0;
    cmp_level_pin <= 32'h0;
    step;
    chk(level, 32'hA5C30F10);
    $display("test masks done");
    @(posedge clk);
    board_enable <= 1'b1;
    channel_off <= 32'h0;
    wr_reg(`IOCS_A_THRSRC, 32'h1);
    wr_reg(`IOCS_A_INDEX, 32'h1);
    wr_reg(`IOCS_A_THRPAR, 32'h5A);
    step;
    chk(thr_out[15:0], 16'h5AC3);
    wr_reg(`IOCS_A_MODELO, 32'h27FF);
    wr_reg(`IOCS_A_DEFLO, 32'h4688);
    wr_reg(`IOCS_A_CTRL, 32'h3);
    repeat (3) @(posedge clk);
    #1 chk({sw_gnd, sw_batt, sw_pd, sw_pu}, {16'h10, 16'h8, 16'h4, 16'h2});
    chk({in_pd, in_pu}, {32'h40, 32'h20});
    @(posedge clk);
    for (i = 0; i < 5; i = i + 1)
      switch_config[3*i +: 3] <= 3'((i + 1) % 5);
    step;
    chk({sw_gnd, sw_batt, sw_pd, sw_pu}, {16'h8, 16'h4, 16'h2, 16'h1});
    $display("test switches done");
    wr_reg(`IOCS_A_INDEX, 32'h0);
    wr_reg(`IOCS_A_BIND, 32'h42);
    wr_reg(`IOCS_A_INDEX, 32'h1);
    wr_reg(`IOCS_A_BIND, 32'h03);
    step;
    @(posedge clk);
    timeout_hit <= 64'h1;
    @(posedge clk);
    timeout_hit <= 64'h0;
    step;
    chk(expiry, {{62{2'h2}}, 2'h0, 2'h1});
    chk(measure_run[2:0], 3'h3);
    @(posedge clk);
    channel_off <= 32'h4;
    step;
    chk(expiry[3:0], 4'h1);
    $display("test expiry done");
    @(posedge clk);
    channel_off <= 32'h0;
    wr_reg(`IOCS_A_FRAC, 32'h400);
    wr_reg(`IOCS_A_CTRL, 32'h9);
    n0 = rx_cnt;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk);
      angle <= (i == 0) ? 16'd100 : (i == 1) ? 16'd111 : (i == 2) ? 16'd112 : 16'd850;
      step;
      n0 = n0 + ((i == 1) ? 8'h00 : 8'h01);
      chk(rx_cnt, n0);
    end
    chk(rx_data, 16'h02D0);
    $display("test transfer done");
    wr_reg(`IOCS_A_IEN, 32'h1);
    @(posedge clk);
    overcurrent_pin <= 1'b1;
    // two sync stages and the trip flop before a step can see it
    repeat (2) @(posedge clk);
    step;
    chk({overload_trip, supply_off, irq}, 3'h7);
    chk({chan_active, sw_pu | sw_pd | sw_batt | sw_gnd}, 48'h0);
    @(posedge clk);
    overcurrent_pin <= 1'b0;
    step;
    chk(overload_trip, 1'b1);
    wr_reg(`IOCS_A_IEN, 32'h0);
    chk(irq, 1'b0);
    wr_reg(`IOCS_A_IEN, 32'h1);
    chk(irq, 1'b1);
    wr_reg(`IOCS_A_ICLR, 32'h1);
    chk(irq, 1'b0);
    wr_reg(`IOCS_A_CTRL, 32'h5);
    step;
    chk(overload_trip, 1'b0);
    rd_reg(`IOCS_A_STAT, 32'h4);
    $display("test overload done");
    give_verdict;
  end
endmodule
